// ---- logic/rcrl_pkg.sv ----
`default_nettype none
package rcrl_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CAUSE = 12'hff0;
    localparam logic [11:0] OFF_UPPER = 12'hff4;
    localparam logic [11:0] OFF_HIGH = 12'hff8;
    localparam logic [11:0] OFF_LOW = 12'hffc;
    localparam logic [11:0] OFF_IRQ_ST = 12'hfe0;
    localparam logic [11:0] OFF_IRQ_MASK = 12'hfe4;
    localparam logic [11:0] OFF_DBGCTL = 12'hfe8;
    // ------------------------------------------------------------
    // Unlock keys and cause codes (bits 7..4 of the cause register)
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [3:0] CAUSE_POR = 4'h8;
    localparam logic [3:0] CAUSE_STOP = 4'h4;
    localparam logic [3:0] CAUSE_WDT = 4'h2;
    localparam logic [3:0] CAUSE_EXT = 4'h1;
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_LOW_BITS = 4'h0;
    // ------------------------------------------------------------
    // Sequencer counts and debugger control layout
    // ------------------------------------------------------------
    localparam logic [6:0] POR_LAST = 7'h41;
    localparam logic [4:0] XTAL_LAST = 5'h0f;
    localparam logic [7:0] DBG_WMASK = 8'hc1;
    localparam logic [7:0] DBG_SELFCLR = 8'hfe;
    localparam int DBG_RST_BIT = 0;
    localparam int DBG_MODE_BIT = 7;
    localparam logic [7:0] RELOAD_RST = 8'hff;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEQ_HOLD = 4'h1,
        SEQ_POR = 4'h2,
        SEQ_XTAL = 4'h4,
        SEQ_RUN = 4'h8
    } rcrl_seq_t;
    typedef enum logic [2:0] {
        LK_LOCKED = 3'h1,
        LK_HALF = 3'h2,
        LK_OPEN = 3'h4
    } rcrl_lock_t;
endpackage : rcrl_pkg
`default_nettype wire

// ---- logic/rcrl_top.sv ----
// Implementation choice: the APB register port.
`default_nettype none
module rcrl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic wdt_osc_tick,
    input wire logic reset_pin_n,
    input wire logic debug_pin,
    input wire logic stop_mode,
    input wire logic gpio_wake,
    input wire logic wdt_timeout,
    input wire logic wdt_reset_mode,
    input wire logic wdt_enable,
    input wire logic wdt_refresh,
    output logic sys_reset_n,
    output logic dbg_reset_n,
    output logic fetch_vector,
    output logic stop_wake,
    output logic debug_mode,
    output logic wdt_load,
    output logic [7:0] reload_upper_byte,
    output logic [7:0] reload_high_byte,
    output logic [7:0] reload_low_byte,
    output logic irq
);
    // ------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------
    function automatic logic rcrl_hit(input logic [11:0] addr, input logic [11:0] off);
        rcrl_hit = (addr == off);
    endfunction : rcrl_hit

    rcrl_pkg::rcrl_seq_t state, next_state;
    rcrl_pkg::rcrl_lock_t lock, next_lock;
    logic por_path, next_por_path;
    logic keep_dbg, next_keep_dbg;
    logic [6:0] por_cnt;
    logic [4:0] xtal_cnt;
    logic [3:0] cause, next_cause;
    logic [7:0] dbgctl, next_dbgctl;
    logic [3:0] irq_st, irq_mask, next_irq_st, next_irq_mask;
    logic wdt_en_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic setup = psel & ~penable;
    wire logic acc = psel & penable & pready;
    wire logic wr = acc & pwrite;
    wire logic rd = acc & ~pwrite;
    wire logic [7:0] wdata = pwdata[7:0];
    wire logic sel_cause = rcrl_hit(paddr, rcrl_pkg::OFF_CAUSE);
    wire logic sel_upper = rcrl_hit(paddr, rcrl_pkg::OFF_UPPER);
    wire logic sel_high = rcrl_hit(paddr, rcrl_pkg::OFF_HIGH);
    wire logic sel_low = rcrl_hit(paddr, rcrl_pkg::OFF_LOW);
    wire logic sel_st = rcrl_hit(paddr, rcrl_pkg::OFF_IRQ_ST);
    wire logic sel_mask = rcrl_hit(paddr, rcrl_pkg::OFF_IRQ_MASK);
    wire logic sel_dbg = rcrl_hit(paddr, rcrl_pkg::OFF_DBGCTL);
    wire logic sel_reload = sel_upper | sel_high | sel_low;
    wire logic mapped = sel_cause | sel_reload | sel_st | sel_mask | sel_dbg;
    wire logic [31:0] rdata =
        sel_cause ? {24'h0, cause, rcrl_pkg::CAUSE_LOW_BITS} :
        sel_upper ? {24'h0, reload_upper_byte} :
        sel_high ? {24'h0, reload_high_byte} :
        sel_low ? {24'h0, reload_low_byte} :
        sel_st ? {28'h0, irq_st} :
        sel_mask ? {28'h0, irq_mask} :
        sel_dbg ? {24'h0, dbgctl} : 32'h0;

    // ------------------------------------------------------------
    // Reset and recovery sources
    // ------------------------------------------------------------
    wire logic running = (state == rcrl_pkg::SEQ_RUN);
    wire logic src_pwr = ~supply_ok;
    wire logic src_pin = ~reset_pin_n;
    wire logic src_dbgpin = stop_mode & ~debug_pin;
    wire logic level_src = src_pwr | src_pin | src_dbgpin;
    wire logic src_wdt = running & ~stop_mode & wdt_timeout & wdt_reset_mode;
    wire logic src_dbg = running & ~stop_mode & wr & sel_dbg & pwdata[rcrl_pkg::DBG_RST_BIT];
    wire logic reset_evt = running & (level_src | src_wdt | src_dbg);
    wire logic wake_gpio = running & stop_mode & ~level_src & gpio_wake;
    wire logic wake_wdt = running & stop_mode & ~level_src & wdt_timeout;
    wire logic wake_evt = wake_gpio | wake_wdt;
    wire logic cause_evt = reset_evt | wake_evt | (~running & level_src);
    wire logic dbg_only = src_dbg & ~(level_src | src_wdt);

    // Cause code, highest priority first
    wire logic [3:0] wake_code =
        rcrl_pkg::CAUSE_STOP | (wake_wdt ? rcrl_pkg::CAUSE_WDT : rcrl_pkg::CAUSE_NONE);
    wire logic [3:0] new_code =
        src_pwr ? rcrl_pkg::CAUSE_POR :
        src_pin ? rcrl_pkg::CAUSE_EXT :
        src_dbgpin ? rcrl_pkg::CAUSE_POR :
        src_wdt ? rcrl_pkg::CAUSE_WDT :
        wake_evt ? wake_code : rcrl_pkg::CAUSE_POR;

    // Read clears only the bits the reader was shown; a new event wins
    wire logic [3:0] rd_clear = (rd & sel_cause) ? prdata[7:4] : rcrl_pkg::CAUSE_NONE;
    assign next_cause = cause_evt ? new_code : (cause & ~rd_clear);

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_por_path = por_path | src_pwr;
        case (state)
            rcrl_pkg::SEQ_RUN:
            begin
                next_por_path = src_pwr;
                if (reset_evt)
                    next_state = rcrl_pkg::SEQ_HOLD;
            end
            rcrl_pkg::SEQ_HOLD:
            begin
                if (!level_src)
                    next_state = por_path ? rcrl_pkg::SEQ_POR : rcrl_pkg::SEQ_XTAL;
            end
            rcrl_pkg::SEQ_POR:
            begin
                if (level_src)
                    next_state = rcrl_pkg::SEQ_HOLD;
                else if (wdt_osc_tick && por_cnt == rcrl_pkg::POR_LAST)
                    next_state = rcrl_pkg::SEQ_XTAL;
            end
            rcrl_pkg::SEQ_XTAL:
            begin
                if (level_src)
                    next_state = rcrl_pkg::SEQ_HOLD;
                else if (xtal_cnt == rcrl_pkg::XTAL_LAST)
                    next_state = rcrl_pkg::SEQ_RUN;
            end
            default:
            begin
                next_state = rcrl_pkg::SEQ_HOLD;
                next_por_path = 1'b1;
            end
        endcase
    end

    // Debugger logic survives only a reset that the debugger alone asked for
    assign next_keep_dbg = reset_evt ? dbg_only : ((~running & level_src) ? 1'b0 : keep_dbg);
    wire logic next_run = (next_state == rcrl_pkg::SEQ_RUN);
    wire logic rst_done = next_run & ~running;

    // Sequencer registers and reset outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= rcrl_pkg::SEQ_HOLD;
            por_path <= 1'b1;
            keep_dbg <= 1'b0;
            cause <= rcrl_pkg::CAUSE_POR;
            sys_reset_n <= 1'b0;
            dbg_reset_n <= 1'b0;
            fetch_vector <= 1'b0;
            stop_wake <= 1'b0;
        end
        else
        begin
            state <= next_state;
            por_path <= next_por_path;
            keep_dbg <= next_keep_dbg;
            cause <= next_cause;
            sys_reset_n <= next_run;
            dbg_reset_n <= next_run | next_keep_dbg;
            fetch_vector <= rst_done;
            stop_wake <= wake_evt;
        end
    end

    // Power-on tick counter and settle counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_cnt <= 7'h0;
            xtal_cnt <= 5'h0;
        end
        else
        begin
            por_cnt <= (state != rcrl_pkg::SEQ_POR) ? 7'h0 : por_cnt + 7'(wdt_osc_tick);
            xtal_cnt <= (state != rcrl_pkg::SEQ_XTAL) ? 5'h0 : xtal_cnt + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // Reload unlock state machine
    // ------------------------------------------------------------
    wire logic key1 = wr & sel_cause & (wdata == rcrl_pkg::KEY_FIRST);
    wire logic key2 = wr & sel_cause & (wdata == rcrl_pkg::KEY_SECOND);
    wire logic is_open = (lock == rcrl_pkg::LK_OPEN);
    wire logic reload_ok = wr & is_open & sel_reload;
    wire logic refused = wr & sel_reload & ~is_open;
    wire logic abort = wr & (((lock == rcrl_pkg::LK_HALF) & ~key2) | (is_open & ~sel_reload));

    always_comb
    begin
        next_lock = lock;
        case (lock)
            rcrl_pkg::LK_LOCKED:
            begin
                if (key1)
                    next_lock = rcrl_pkg::LK_HALF;
            end
            rcrl_pkg::LK_HALF:
            begin
                if (wr)
                    next_lock = key2 ? rcrl_pkg::LK_OPEN : rcrl_pkg::LK_LOCKED;
            end
            rcrl_pkg::LK_OPEN:
            begin
                if (wr && !(sel_upper || sel_high))
                    next_lock = rcrl_pkg::LK_LOCKED;
            end
            default:
            begin
                next_lock = rcrl_pkg::LK_LOCKED;
            end
        endcase
        if (!running)
            next_lock = rcrl_pkg::LK_LOCKED;
    end

    // Lock state and reload bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock <= rcrl_pkg::LK_LOCKED;
            reload_upper_byte <= rcrl_pkg::RELOAD_RST;
            reload_high_byte <= rcrl_pkg::RELOAD_RST;
            reload_low_byte <= rcrl_pkg::RELOAD_RST;
        end
        else
        begin
            lock <= next_lock;
            if (reload_ok && sel_upper)
                reload_upper_byte <= wdata;
            if (reload_ok && sel_high)
                reload_high_byte <= wdata;
            if (reload_ok && sel_low)
                reload_low_byte <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Debugger control, watchdog load, interrupts, bus answer
    // ------------------------------------------------------------
    wire logic dbg_wipe = ~running & ~keep_dbg;
    assign next_dbgctl = dbg_wipe ? 8'h0 :
        (wr & sel_dbg) ? (wdata & rcrl_pkg::DBG_WMASK) : (dbgctl & rcrl_pkg::DBG_SELFCLR);
    wire logic [3:0] irq_set = {refused, abort, wake_evt, rst_done};
    wire logic [3:0] irq_clr = (wr & sel_st) ? pwdata[3:0] : rcrl_pkg::IRQ_NONE;
    assign next_irq_st = irq_set | (irq_st & ~irq_clr);
    assign next_irq_mask = (wr & sel_mask) ? pwdata[3:0] : irq_mask;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbgctl <= 8'h0;
            debug_mode <= 1'b0;
            wdt_en_q <= 1'b0;
            wdt_load <= 1'b0;
            irq_st <= rcrl_pkg::IRQ_NONE;
            irq_mask <= rcrl_pkg::IRQ_NONE;
            irq <= 1'b0;
        end
        else
        begin
            dbgctl <= next_dbgctl;
            debug_mode <= next_dbgctl[rcrl_pkg::DBG_MODE_BIT];
            wdt_en_q <= wdt_enable;
            wdt_load <= (wdt_enable & ~wdt_en_q) | wdt_refresh;
            irq_st <= next_irq_st;
            irq_mask <= next_irq_mask;
            irq <= |(next_irq_st & next_irq_mask);
        end
    end

    // APB answer: one wait-free access phase, data latched at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup)
            begin
                prdata <= rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic [3:0] seen_hi = prdata[7:4];

    AST_POR_COUNT: assert property (
        (state == rcrl_pkg::SEQ_XTAL && $past(state) == rcrl_pkg::SEQ_POR)
        |-> ($past(por_cnt) == rcrl_pkg::POR_LAST && $past(wdt_osc_tick)))
        else $error("power-on count left early");
    AST_XTAL_COUNT: assert property (
        ($rose(state == rcrl_pkg::SEQ_XTAL) && !level_src)
        ##0 (!level_src)[*8] |-> !sys_reset_n)
        else $error("settle count ended early");
    AST_HELD: assert property (
        (state != rcrl_pkg::SEQ_RUN
            && !(state == rcrl_pkg::SEQ_XTAL && xtal_cnt == rcrl_pkg::XTAL_LAST))
        |=> !sys_reset_n)
        else $error("reset released before sequence end");
    AST_FETCH: assert property (
        $rose(sys_reset_n) |-> fetch_vector)
        else $error("no vector fetch on release");
    AST_PIN_RESET: assert property (
        (running && src_pin && supply_ok) |=> (!sys_reset_n && cause == rcrl_pkg::CAUSE_EXT))
        else $error("pin reset not taken");
    AST_DBG_RESET: assert property (
        dbg_only |=> (!sys_reset_n && dbg_reset_n && cause == rcrl_pkg::CAUSE_POR))
        else $error("debugger reset wrong");
    AST_DBGPIN_STOP: assert property (
        (running && src_dbgpin && supply_ok && reset_pin_n)
        |=> (!sys_reset_n && cause == rcrl_pkg::CAUSE_POR))
        else $error("debug pin reset not taken");
    AST_READ_CLEAR: assert property (
        (rd && sel_cause && !cause_evt) |=> ((cause & $past(seen_hi)) == rcrl_pkg::CAUSE_NONE))
        else $error("read did not clear cause");
    AST_WAKE_WDT: assert property (
        wake_wdt |=> (cause == (rcrl_pkg::CAUSE_STOP | rcrl_pkg::CAUSE_WDT) && stop_wake))
        else $error("watchdog wake code wrong");
    AST_UNLOCK: assert property (
        (lock == rcrl_pkg::LK_HALF && key2 && running) |=> is_open)
        else $error("unlock pair did not open");
    AST_KEY_NOCHG: assert property (
        (wr && sel_cause && !cause_evt && !$past(cause_evt)) |=> $stable(cause))
        else $error("unlock write changed cause");
    AST_LOW_CLOSES: assert property (
        (is_open && wr && sel_low) |=> (lock == rcrl_pkg::LK_LOCKED))
        else $error("low byte write left lock open");
    AST_BLOCKED: assert property (
        refused |=> $stable(reload_upper_byte) && $stable(reload_low_byte))
        else $error("reload written while locked");
    AST_LOAD: assert property (
        (wdt_refresh || $rose(wdt_enable)) |=> wdt_load)
        else $error("reload not copied");
    AST_LOW_ZERO: assert property (
        (pready && sel_cause) |-> (prdata[3:0] == rcrl_pkg::CAUSE_LOW_BITS))
        else $error("reserved bits not zero");

    COV_POWER_UP: cover property ($rose(sys_reset_n) && cause == rcrl_pkg::CAUSE_POR);
    COV_UNLOCK_WRITE: cover property (reload_ok && sel_low);
    COV_GPIO_WAKE: cover property (wake_gpio);
    COV_DBG_STOP: cover property (dbg_only && pwdata[rcrl_pkg::DBG_MODE_BIT]);
endmodule : rcrl_top
`default_nettype wire

// ---- verification/rcrl_far.sv ----
`default_nettype none
module rcrl_far #(
    parameter int TICK_DIV = 3
) (
    input wire logic pclk,
    input wire logic power_on,
    output var logic supply_ok,
    output var logic wdt_osc_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] div = 8'h00;
    // ----------------------------------------------------------
    // Supply monitor and free-running watchdog oscillator
    // ----------------------------------------------------------
    initial
    begin
        supply_ok = 1'b0;
        wdt_osc_tick = 1'b0;
    end
    // Oscillator never stops, so ticks also arrive while the supply is low
    always @(posedge pclk)
    begin
        supply_ok <= power_on;
        div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
        wdt_osc_tick <= (div == 8'h00);
    end
endmodule : rcrl_far
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK_DIV = 3;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, supply_ok, wdt_osc_tick, sys_reset_n, dbg_reset_n;
    logic fetch_vector, stop_wake, debug_mode, wdt_load, irq;
    logic [7:0] rl_u, rl_h, rl_l, u, h, l;
    logic power_on = 1'b1;
    logic reset_pin_n = 1'b1;
    logic debug_pin = 1'b1;
    logic stop_mode = 1'b0;
    logic gpio_wake = 1'b0;
    logic wdt_timeout = 1'b0;
    logic wdt_reset_mode = 1'b1;
    logic wdt_enable = 1'b0;
    logic wdt_refresh = 1'b0;
    int errors = 0;
    int total_checks = 0;
    int seed = 71378;
    int loads = 0;
    int wakes = 0;
    int n;
    logic [32:0] exp_q [$];
    logic [32:0] note;
    logic [3:0] causes [7] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h8, 4'h8};

    always #5 pclk = ~pclk;

    rcrl_top rcrl_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
        .wdt_osc_tick(wdt_osc_tick), .reset_pin_n(reset_pin_n), .debug_pin(debug_pin),
        .stop_mode(stop_mode), .gpio_wake(gpio_wake), .wdt_timeout(wdt_timeout),
        .wdt_reset_mode(wdt_reset_mode), .wdt_enable(wdt_enable),
        .wdt_refresh(wdt_refresh), .sys_reset_n(sys_reset_n), .dbg_reset_n(dbg_reset_n),
        .fetch_vector(fetch_vector), .stop_wake(stop_wake), .debug_mode(debug_mode),
        .wdt_load(wdt_load), .reload_upper_byte(rl_u), .reload_high_byte(rl_h),
        .reload_low_byte(rl_l), .irq(irq));
    rcrl_far #(.TICK_DIV(TICK_DIV)) rcrl_far_i (.pclk(pclk), .power_on(power_on),
        .supply_ok(supply_ok), .wdt_osc_tick(wdt_osc_tick));

    // ----------------------------------------------------------
    // Output watcher and bus tasks
    // ----------------------------------------------------------
    // Oldest note against each read answer; pulse counters
    always @(posedge pclk)
    begin
        loads <= loads + int'(wdt_load === 1'b1);
        wakes <= wakes + int'(stop_wake === 1'b1);
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            `CHK("read", note, {pslverr, prdata})
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Waits for reset release; vector fetch comes with it
    task automatic wait_run();
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("released", 1'b1, sys_reset_n)
        `CHK("fetch", 1'b1, fetch_vector)
    endtask : wait_run

    task automatic unlock_test();
        u = 8'($random(seed));
        h = 8'($random(seed));
        l = 8'($random(seed));
        apb(1'b1, rcrl_pkg::OFF_CAUSE, 32'h55);
        apb(1'b1, rcrl_pkg::OFF_CAUSE, 32'haa);
        apb(1'b1, rcrl_pkg::OFF_UPPER, {24'h0, u});
        apb(1'b1, rcrl_pkg::OFF_HIGH, {24'h0, h});
        apb(1'b1, rcrl_pkg::OFF_LOW, {24'h0, l});
        apb(1'b1, rcrl_pkg::OFF_UPPER, {24'h0, ~u});
        `CHK("reload", {u, h, l}, {rl_u, rl_h, rl_l})
        apb(1'b1, rcrl_pkg::OFF_IRQ_ST, 32'hf);
        apb(1'b1, rcrl_pkg::OFF_CAUSE, 32'h55);
        apb(1'b1, rcrl_pkg::OFF_IRQ_MASK, 32'h8);
        apb(1'b1, rcrl_pkg::OFF_CAUSE, 32'haa);
        apb(1'b1, rcrl_pkg::OFF_HIGH, {24'h0, ~h});
        `CHK("relocked", h, rl_h)
        rd(rcrl_pkg::OFF_IRQ_ST, 33'h0c);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, rcrl_pkg::OFF_IRQ_ST, 32'h8);
        @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        $display("test unlock done");
    endtask : unlock_test

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        `CHK("reload reset", 24'hffffff, {rl_u, rl_h, rl_l})
        `CHK("held", 1'b0, sys_reset_n)
        presetn <= 1'b1;
        wait_run();
        `CHK("por span", 1'b1, n >= 65 * TICK_DIV + 16 && n <= 66 * TICK_DIV + 22)
        rd(rcrl_pkg::OFF_CAUSE, 33'h080);
        rd(rcrl_pkg::OFF_CAUSE, 33'h000);
        rd(12'h100, {1'b1, 32'h0});
        $display("test power on done");
        // Reset and recovery sources, one per pass
        for (int k = 0; k < 7; k++)
        begin
            stop_mode <= (k >= 2 && k <= 4);
            @(posedge pclk);
            case (k)
                0: reset_pin_n <= 1'b0;
                1: wdt_timeout <= 1'b1;
                2: gpio_wake <= 1'b1;
                3: wdt_timeout <= 1'b1;
                4: debug_pin <= 1'b0;
                5: power_on <= 1'b0;
                default: apb(1'b1, rcrl_pkg::OFF_DBGCTL, 32'h81);
            endcase
            @(posedge pclk);
            wdt_timeout <= 1'b0;
            gpio_wake <= 1'b0;
            repeat (4) @(posedge pclk);
            reset_pin_n <= 1'b1;
            debug_pin <= 1'b1;
            power_on <= 1'b1;
            stop_mode <= 1'b0;
            @(posedge pclk);
            if (k == 2 || k == 3)
                `CHK("wake", k - 1, wakes)
            else
            begin
                `CHK("held", 1'b0, sys_reset_n)
                if (k == 6)
                    `CHK("dbg kept", 1'b1, dbg_reset_n)
                wait_run();
            end
            if (k == 0)
                unlock_test();
            rd(rcrl_pkg::OFF_CAUSE, {25'h0, causes[k], 4'h0});
            $display("test source %0d done", k);
        end
        `CHK("stopped", 1'b1, debug_mode)
        apb(1'b1, rcrl_pkg::OFF_DBGCTL, 32'h40);
        `CHK("running", 1'b0, debug_mode)
        apb(1'b1, rcrl_pkg::OFF_DBGCTL, 32'h41);
        `CHK("go reset", 1'b0, sys_reset_n)
        wait_run();
        `CHK("go runs", 1'b0, debug_mode)
        rd(rcrl_pkg::OFF_CAUSE, 33'h080);
        $display("test debugger go done");
        // Timeout without reset mode leaves the system running
        wdt_reset_mode <= 1'b0;
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("no wdt reset", 1'b1, sys_reset_n)
        rd(rcrl_pkg::OFF_CAUSE, 33'h000);
        $display("test watchdog no reset done");
        wdt_enable <= 1'b1;
        repeat (4) @(posedge pclk);
        wdt_refresh <= 1'b1;
        @(posedge pclk);
        wdt_refresh <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("loads", 2, loads)
        $display("test reload copy done");
        `CHK("queue", 0, exp_q.size())
        complete_run();
    end

    // Cuts a hang short
    initial
    begin
        #500000;
        errors++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
